// ==== src/siw_pkg.sv ====
// Package of register indexes, ports, field positions and reset values for the socket I/O block.
`default_nettype none
package siw_pkg;
    localparam logic [15:0] SIW_INDEX_PORT   = 16'h0022;
    localparam logic [15:0] SIW_DATA_PORT    = 16'h0023;
    localparam logic [7:0]  SIW_WIN1_START   = 8'h00;
    localparam logic [7:0]  SIW_WIN1_END     = 8'h01;
    localparam logic [7:0]  SIW_WIN1_UPPER   = 8'h02;
    localparam logic [7:0]  SIW_WIN2_START   = 8'h03;
    localparam logic [7:0]  SIW_WIN2_END     = 8'h04;
    localparam logic [7:0]  SIW_WIN2_UPPER   = 8'h05;
    localparam logic [7:0]  SIW_IRQ_ROUTE    = 8'h06;
    localparam logic [7:0]  SIW_REG_RESET    = 8'h00;
    localparam int          SIW_WIN1_EN_BIT  = 0;
    localparam int          SIW_WIN2_EN_BIT  = 1;
    localparam int          SIW_IO_EN_BIT    = 2;
    localparam int          SIW_INVERT_BIT   = 3;
    localparam int          SIW_SELECT_LSB   = 4;
    localparam int          SIW_SELECT_MSB   = 7;
endpackage : siw_pkg
`default_nettype wire

// ==== src/siw_window_match.sv ====
// One I/O window range comparator.
`timescale 1ns/1ps
`default_nettype none
module siw_window_match
    import siw_pkg::*;
(
    input  wire logic [15:0] i_address,
    input  wire logic [7:0]  i_start_low,
    input  wire logic [7:0]  i_end_low,
    input  wire logic [7:0]  i_upper,
    input  wire logic        i_enable,
    output logic             o_hit
);
    logic [15:0] start_address;
    logic [15:0] end_address;

    assign start_address = {i_upper, i_start_low};
    assign end_address   = {i_upper, i_end_low};
    // An inverted range (end below start) never matches.
    assign o_hit = i_enable && (i_address >= start_address)
                   && (i_address <= end_address);
endmodule : siw_window_match
`default_nettype wire

// ==== src/siw_socket_io.sv ====
// Indexed configuration ports, socket I/O window decode and card interrupt routing.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module siw_socket_io
    import siw_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_clock_enable,
    input  wire logic [15:0] i_io_address,
    input  wire logic        i_io_read,
    input  wire logic        i_io_write,
    input  wire logic [7:0]  i_io_write_data,
    input  wire logic        i_card_interrupt_request,
    output logic [7:0]       o_io_read_data,
    output logic             o_io_read_valid,
    output logic             o_card_register_select,
    output logic             o_card_enable_low,
    output logic             o_card_enable_high,
    output logic [15:0]      o_system_irq
);
    logic [7:0] config_index_port;
    logic [7:0] win1_start_low;
    logic [7:0] win1_end_low;
    logic [7:0] win1_upper;
    logic [7:0] win2_start_low;
    logic [7:0] win2_end_low;
    logic [7:0] win2_upper;
    logic [7:0] card_irq_route_ctrl;
    logic [7:0] read_data;
    logic       read_valid;
    logic [7:0] next_config_index_port;
    logic [7:0] next_win1_start_low;
    logic [7:0] next_win1_end_low;
    logic [7:0] next_win1_upper;
    logic [7:0] next_win2_start_low;
    logic [7:0] next_win2_end_low;
    logic [7:0] next_win2_upper;
    logic [7:0] next_card_irq_route_ctrl;
    logic [7:0] next_read_data;
    logic       next_read_valid;
    logic [7:0] selected_value;
    logic       index_access;
    logic       data_access;
    logic       index_write;
    logic       index_read;
    logic       data_write;
    logic       data_read;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration port access.
    assign index_access = (i_io_address == SIW_INDEX_PORT);
    assign data_access  = (i_io_address == SIW_DATA_PORT);
    assign index_write  = i_io_write && index_access;
    assign index_read   = i_io_read && index_access;
    assign data_write   = i_io_write && data_access;
    assign data_read    = i_io_read && data_access;

    // Indexes beyond the implemented set read as zero, so software probing for
    // further registers sees an empty slot rather than an alias of a low one.
    always_comb begin
        selected_value = SIW_REG_RESET;
        case (config_index_port)
            SIW_WIN1_START: begin
                selected_value = win1_start_low;
            end
            SIW_WIN1_END: begin
                selected_value = win1_end_low;
            end
            SIW_WIN1_UPPER: begin
                selected_value = win1_upper;
            end
            SIW_WIN2_START: begin
                selected_value = win2_start_low;
            end
            SIW_WIN2_END: begin
                selected_value = win2_end_low;
            end
            SIW_WIN2_UPPER: begin
                selected_value = win2_upper;
            end
            SIW_IRQ_ROUTE: begin
                selected_value = card_irq_route_ctrl;
            end
            default: begin
                selected_value = SIW_REG_RESET;
            end
        endcase
    end

    // A port read answers one cycle later with a one-cycle valid; the data
    // then stay until the next port read.
    // A data access uses the index held before its cycle, so an index write
    // followed by a data write in the next cycle already sees the new index.
    always_comb begin
        next_config_index_port = config_index_port;
        next_read_data         = read_data;
        next_read_valid        = 1'b0;
        if (index_write) begin
            next_config_index_port = i_io_write_data;
        end
        if (index_read) begin
            next_read_data  = config_index_port;
            next_read_valid = 1'b1;
        end
        if (data_read) begin
            next_read_data  = selected_value;
            next_read_valid = 1'b1;
        end
    end

    // A low clock enable freezes every register; the card strobes are
    // combinational and still follow the host cycle.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            config_index_port <= SIW_REG_RESET;
            read_data         <= SIW_REG_RESET;
            read_valid        <= 1'b0;
        end else if (i_clock_enable) begin
            config_index_port <= next_config_index_port;
            read_data         <= next_read_data;
            read_valid        <= next_read_valid;
        end
    end

    assign o_io_read_data  = read_data;
    assign o_io_read_valid = read_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    // Writes to indexes beyond the implemented set are dropped.
    always_comb begin
        next_win1_start_low      = win1_start_low;
        next_win1_end_low        = win1_end_low;
        next_win1_upper          = win1_upper;
        next_win2_start_low      = win2_start_low;
        next_win2_end_low        = win2_end_low;
        next_win2_upper          = win2_upper;
        next_card_irq_route_ctrl = card_irq_route_ctrl;
        if (data_write) begin
            case (config_index_port)
                SIW_WIN1_START: begin
                    next_win1_start_low = i_io_write_data;
                end
                SIW_WIN1_END: begin
                    next_win1_end_low = i_io_write_data;
                end
                SIW_WIN1_UPPER: begin
                    next_win1_upper = i_io_write_data;
                end
                SIW_WIN2_START: begin
                    next_win2_start_low = i_io_write_data;
                end
                SIW_WIN2_END: begin
                    next_win2_end_low = i_io_write_data;
                end
                SIW_WIN2_UPPER: begin
                    next_win2_upper = i_io_write_data;
                end
                SIW_IRQ_ROUTE: begin
                    next_card_irq_route_ctrl = i_io_write_data;
                end
                default: begin
                    next_card_irq_route_ctrl = card_irq_route_ctrl;
                end
            endcase
        end
    end

    // Reset leaves every window as the range 0000h..0000h with decoding off.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            win1_start_low      <= SIW_REG_RESET;
            win1_end_low        <= SIW_REG_RESET;
            win1_upper          <= SIW_REG_RESET;
            win2_start_low      <= SIW_REG_RESET;
            win2_end_low        <= SIW_REG_RESET;
            win2_upper          <= SIW_REG_RESET;
            card_irq_route_ctrl <= SIW_REG_RESET;
        end else if (i_clock_enable) begin
            win1_start_low      <= next_win1_start_low;
            win1_end_low        <= next_win1_end_low;
            win1_upper          <= next_win1_upper;
            win2_start_low      <= next_win2_start_low;
            win2_end_low        <= next_win2_end_low;
            win2_upper          <= next_win2_upper;
            card_irq_route_ctrl <= next_card_irq_route_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window decode.
    logic [7:0] route_ctrl;
    logic       io_card_enable;
    logic       window1_enable;
    logic       window2_enable;
    logic       card_irq_invert;
    logic [3:0] card_irq_select;
    logic       hit1;
    logic       hit2;
    logic       io_cycle;

    assign route_ctrl      = card_irq_route_ctrl;
    assign io_card_enable  = route_ctrl[SIW_IO_EN_BIT];
    assign window1_enable  = route_ctrl[SIW_WIN1_EN_BIT];
    assign window2_enable  = route_ctrl[SIW_WIN2_EN_BIT];
    assign card_irq_invert = route_ctrl[SIW_INVERT_BIT];
    assign card_irq_select = route_ctrl[SIW_SELECT_MSB:SIW_SELECT_LSB];
    assign io_cycle        = i_io_read || i_io_write;

    siw_window_match u_window1 (
        .i_address   (i_io_address),
        .i_start_low (win1_start_low),
        .i_end_low   (win1_end_low),
        .i_upper     (win1_upper),
        .i_enable    (window1_enable),
        .o_hit       (hit1)
    );

    siw_window_match u_window2 (
        .i_address   (i_io_address),
        .i_start_low (win2_start_low),
        .i_end_low   (win2_end_low),
        .i_upper     (win2_upper),
        .i_enable    (window2_enable),
        .o_hit       (hit2)
    );

    // Strobes are active high here and follow the cycle combinationally, so the
    // card sees them for exactly the duration of the host I/O request.
    logic window_hit;
    logic card_select;
    assign window_hit  = hit1 || hit2;
    assign card_select = io_cycle && io_card_enable && window_hit;
    assign o_card_register_select = card_select;
    assign o_card_enable_low      = card_select;
    assign o_card_enable_high     = card_select;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt routing.
    logic [15:0] next_irq;
    logic [15:0] irq_out;
    logic [15:0] route_mask;
    logic        irq_level;
    logic        irq_forward;

    assign irq_level   = i_card_interrupt_request ^ card_irq_invert;
    assign irq_forward = io_card_enable && (card_irq_select != 4'h0);

    // Every select code is listed, so the reserved ones stay visibly empty
    // instead of falling through to a shift that would light IRQ1, IRQ2, IRQ8 or IRQ13.
    always_comb begin
        route_mask = 16'h0000;
        unique case (card_irq_select)
            4'h0: route_mask = 16'h0000;
            4'h1: route_mask = 16'h0000;
            4'h2: route_mask = 16'h0000;
            4'h3: route_mask = 16'h0008;
            4'h4: route_mask = 16'h0010;
            4'h5: route_mask = 16'h0020;
            4'h6: route_mask = 16'h0040;
            4'h7: route_mask = 16'h0080;
            4'h8: route_mask = 16'h0000;
            4'h9: route_mask = 16'h0200;
            4'hA: route_mask = 16'h0400;
            4'hB: route_mask = 16'h0800;
            4'hC: route_mask = 16'h1000;
            4'hD: route_mask = 16'h0000;
            4'hE: route_mask = 16'h4000;
            4'hF: route_mask = 16'h8000;
        endcase
    end

    // The routed level is registered, so the controller never sees a glitch
    // while software rewrites the select code or the invert bit.
    always_comb begin
        next_irq = 16'h0000;
        if (irq_forward) begin
            next_irq = route_mask & {16{irq_level}};
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            irq_out <= 16'h0000;
        end else if (i_clock_enable) begin
            irq_out <= next_irq;
        end
    end

    assign o_system_irq = irq_out;
endmodule : siw_socket_io
`default_nettype wire

// ==== tb/siw_card_model.sv ====
// Card side model that drives the card interrupt request.
`timescale 1ns/1ps
`default_nettype none
module siw_card_model (
    input  wire logic i_clock,
    input  wire logic i_level,
    output var logic  o_interrupt_request
);
    // The request moves only on the clock, so the bench knows exactly when it was seen.
    always_ff @(posedge i_clock) o_interrupt_request <= i_level;
endmodule : siw_card_model
`default_nettype wire

// ==== tb/siw_socket_io_props.sv ====
// Checker for the port behaviour of the socket I/O block.
`timescale 1ns/1ps
`default_nettype none
module siw_socket_io_props (
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_clock_enable,
    input wire logic [15:0] i_io_address,
    input wire logic        i_io_read,
    input wire logic        i_io_write,
    input wire logic [7:0]  i_io_write_data,
    input wire logic        i_card_interrupt_request,
    input wire logic [7:0]  o_io_read_data,
    input wire logic        o_io_read_valid,
    input wire logic        o_card_register_select,
    input wire logic        o_card_enable_low,
    input wire logic        o_card_enable_high,
    input wire logic [15:0] o_system_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire logic cfg_rd = i_clock_enable && i_io_read && i_io_address[15:1] == 15'h0011;
    AST_READ_ANSWER: assert property (cfg_rd |=> o_io_read_valid)
        else $error("config read not answered");
    AST_VALID_CAUSE: assert property (o_io_read_valid |-> $past(cfg_rd))
        else $error("read valid without a config read");
    AST_RESET_CLEAR: assert property ($past(!i_rstn) |-> o_system_irq == 16'h0000)
        else $error("irq not clear after reset");
    AST_STROBE_PAIR: assert property (o_card_register_select == o_card_enable_low
        && o_card_enable_low == o_card_enable_high) else $error("card strobes disagree");
    AST_STROBE_CAUSE: assert property (o_card_register_select |-> i_io_read || i_io_write)
        else $error("card strobe without access");
    AST_IRQ_ONEHOT: assert property ($onehot0(o_system_irq))
        else $error("more than one irq line");
    AST_IRQ_RESERVED: assert property ((o_system_irq & 16'h2107) == 16'h0000)
        else $error("irq on a line no code selects");
    AST_IRQ_TOGGLE: assert property (o_system_irq != 16'h0000 && i_clock_enable
        && $past(i_clock_enable) && !$past(i_io_write) && $changed(i_card_interrupt_request)
        |=> o_system_irq == 16'h0000) else $error("irq did not follow request");
endmodule : siw_socket_io_props
`default_nettype wire

// ==== tb/socket_io_window_irq_route_bench.sv ====
// Self-checking bench for window decode and card interrupt routing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module socket_io_window_irq_route_bench;
    import siw_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, rd = 1'b0, wr = 1'b0, lvl = 1'b0;
    logic [15:0] addr = 16'h0000, irq, s, e;
    logic [7:0]  wdat = 8'h00, rdat, ctl, lo, hi, up, d;
    logic        vld, sel, cel, ceh, req;
    int          mismatches = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    siw_card_model CARD (.i_clock(clk), .i_level(lvl), .o_interrupt_request(req));
    siw_socket_io DUT (.i_clock(clk), .i_rstn(rstn), .i_clock_enable(ce), .i_io_address(addr),
        .i_io_read(rd), .i_io_write(wr), .i_io_write_data(wdat), .i_card_interrupt_request(req),
        .o_io_read_data(rdat), .o_io_read_valid(vld), .o_card_register_select(sel),
        .o_card_enable_low(cel), .o_card_enable_high(ceh), .o_system_irq(irq));
    task automatic wr_port(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_port
    task automatic set_reg(input logic [7:0] i, input logic [7:0] v);
        wr_port(SIW_INDEX_PORT, i);
        wr_port(SIW_DATA_PORT, v);
    endtask : set_reg
    task automatic rd_check(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("read valid", 1'b1, vld)
        `CHK("read data", x, rdat)
    endtask : rd_check
    // Strobes are combinational, so they are judged inside the access cycle.
    task automatic probe(input logic [15:0] a, input logic [2:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        #1 `CHK("card strobes", x, {sel, cel, ceh})
        @(posedge clk);
        rd <= 1'b0;
    endtask : probe
    function automatic logic [15:0] exp_irq(input logic [7:0] c, input logic r);
        if (!c[SIW_IO_EN_BIT] || c[7:4] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hD}) return 16'h0000;
        return {15'h0000, r ^ c[SIW_INVERT_BIT]} << c[7:4];
    endfunction : exp_irq
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(78));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr_port(SIW_INDEX_PORT, 8'(i));
            rd_check(SIW_INDEX_PORT, 8'(i));
            rd_check(SIW_DATA_PORT, 8'h00);
            d = 8'($urandom);
            wr_port(SIW_DATA_PORT, d);
            rd_check(SIW_DATA_PORT, (i < 7) ? d : 8'h00);
        end
        $display("test registers done");
        // A second reset mid-run also leaves the second window at 0000h..0000h for the decode test.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int w = 0; w < 2; w++) begin
            lo = 8'($urandom_range(254, 1));
            hi = 8'($urandom_range(254, lo));
            up = 8'($urandom_range(255, 1));
            s = {up, lo};
            e = {up, hi};
            set_reg(8'(3 * w), lo);
            set_reg(8'(3 * w + 1), hi);
            set_reg(8'(3 * w + 2), up);
            set_reg(SIW_IRQ_ROUTE, 8'h03);
            probe(s, 3'b000);
            set_reg(SIW_IRQ_ROUTE, 8'(4 + (2 >> w)));
            probe(e, 3'b000);
            set_reg(SIW_IRQ_ROUTE, 8'(4 + (1 << w)));
            probe(s, 3'b111);
            probe(e, 3'b111);
            probe(s - 16'h0001, 3'b000);
            probe(e + 16'h0001, 3'b000);
            set_reg(8'(3 * w + 2), 8'h00);
        end
        $display("test windows done");
        for (int k = 0; k < 48; k++) begin
            ctl = (k < 32) ? {4'(k), 1'(k >> 4), 3'b100} : 8'($urandom);
            set_reg(SIW_IRQ_ROUTE, ctl);
            lvl <= 1'($urandom);
            repeat (3) @(posedge clk);
            #1 `CHK("system irq", exp_irq(ctl, lvl), irq)
        end
        $display("test interrupts done");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : socket_io_window_irq_route_bench
bind siw_socket_io siw_socket_io_props u_props (.*);
`default_nettype wire
